// File: design/arj_result_regs.sv
// result byte registers with left or right justification, ahb-lite slave
`timescale 1ns/1ps
module arj_result_regs (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic conv_done,
    input wire logic [9:0] conversion_result,
    output logic result_format_select
);
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
    logic conv_busy;
    logic addr_valid;
    logic ap_write;
    logic ap_read;
    logic [11:0] ap_addr;
    logic dp_write;
    logic [11:0] dp_addr;
    logic wr_high;
    logic wr_low;
    logic wr_ctrl;
    logic rd_high;
    logic rd_low;
    logic rd_ctrl;
    logic busy_clear;
    wire logic [7:0] left_high;
    wire logic [7:0] left_low;
    wire logic [7:0] right_high;
    wire logic [7:0] right_low;
    logic [7:0] next_high;
    logic [7:0] next_low;
    logic [31:0] next_rdata;
    logic next_format;
    logic next_busy;

    // transfer qualification in the address phase
    assign addr_valid = hsel && hready
        && (htrans == arj_pkg::HTRANS_NONSEQ);
    assign ap_write = addr_valid && hwrite;
    assign ap_read = addr_valid && !hwrite;
    assign ap_addr = haddr[arj_pkg::ADDR_W-1:0];

    // write data phase flag
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dp_write <= 1'h0;
        end else begin
            dp_write <= ap_write;
        end
    end

    // write data phase address
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dp_addr <= arj_pkg::ADDR_RESET;
        end else if (ap_write) begin
            dp_addr <= ap_addr;
        end
    end

    // write decode in the data phase
    assign wr_high = dp_write && (dp_addr == arj_pkg::OFF_HIGH);
    assign wr_low = dp_write && (dp_addr == arj_pkg::OFF_LOW);
    assign wr_ctrl = dp_write && (dp_addr == arj_pkg::OFF_CTRL);

    // read decode in the address phase
    assign rd_high = ap_read && (ap_addr == arj_pkg::OFF_HIGH);
    assign rd_low = ap_read && (ap_addr == arj_pkg::OFF_LOW);
    assign rd_ctrl = ap_read && (ap_addr == arj_pkg::OFF_CTRL);

    // read data select, unmapped offsets read zero
    always_comb begin
        next_rdata = arj_pkg::RDATA_ZERO;
        if (rd_high) begin
            next_rdata[arj_pkg::BYTE_W-1:0] = result_high_byte;
        end
        if (rd_low) begin
            next_rdata[arj_pkg::BYTE_W-1:0] = result_low_byte;
        end
        if (rd_ctrl) begin
            next_rdata[arj_pkg::FMT_BIT] = result_format_select;
            next_rdata[arj_pkg::BUSY_BIT] = conv_busy;
        end
    end

    // read data, held until the next read
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hrdata <= arj_pkg::RDATA_ZERO;
        end else if (ap_read) begin
            hrdata <= next_rdata;
        end
    end

    // zero wait states
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hreadyout <= arj_pkg::HREADY_ON;
        end else begin
            hreadyout <= arj_pkg::HREADY_ON;
        end
    end

    // every answer is okay
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hresp <= arj_pkg::HRESP_OKAY;
        end else begin
            hresp <= arj_pkg::HRESP_OKAY;
        end
    end

    // format select control
    always_comb begin
        next_format = result_format_select;
        if (wr_ctrl) begin
            next_format = hwdata[arj_pkg::FMT_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            result_format_select <= arj_pkg::FMT_LEFT;
        end else begin
            result_format_select <= next_format;
        end
    end

    // done flag: write one clears, a landing conversion wins
    assign busy_clear = wr_ctrl && hwdata[arj_pkg::BUSY_BIT];

    always_comb begin
        next_busy = conv_busy;
        if (busy_clear) begin
            next_busy = 1'h0;
        end
        if (conv_done) begin
            next_busy = 1'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            conv_busy <= 1'h0;
        end else begin
            conv_busy <= next_busy;
        end
    end

    // per-bit placement of the result in both formats
    for (genvar b = 0; b < arj_pkg::BYTE_W; b++) begin : g_bit
        assign left_high[b] =
            conversion_result[b + arj_pkg::LEFT_HIGH_SHIFT];
        assign right_low[b] = conversion_result[b];
        if (b >= arj_pkg::LEFT_LOW_POS) begin : g_left_low
            assign left_low[b] =
                conversion_result[b - arj_pkg::LEFT_LOW_POS];
        end else begin : g_left_pad
            assign left_low[b] = 1'h0;
        end
        if (b < arj_pkg::RIGHT_HIGH_BITS) begin : g_right_high
            assign right_high[b] =
                conversion_result[b + arj_pkg::RIGHT_HIGH_SHIFT];
        end else begin : g_right_pad
            assign right_high[b] = 1'h0;
        end
    end

    // high byte chosen by the current format
    always_comb begin
        if (result_format_select == arj_pkg::FMT_LEFT) begin
            next_high = left_high;
        end else begin
            next_high = right_high;
        end
    end

    // low byte chosen by the current format
    always_comb begin
        if (result_format_select == arj_pkg::FMT_LEFT) begin
            next_low = left_low;
        end else begin
            next_low = right_low;
        end
    end

    // high byte: no reset, writable, a conversion wins
    always_ff @(posedge mclk) begin
        if (conv_done) begin
            result_high_byte <= next_high;
        end else if (wr_high) begin
            result_high_byte <= hwdata[arj_pkg::BYTE_W-1:0];
        end
    end

    // low byte: no reset, writable, a conversion wins
    always_ff @(posedge mclk) begin
        if (conv_done) begin
            result_low_byte <= next_low;
        end else if (wr_low) begin
            result_low_byte <= hwdata[arj_pkg::BYTE_W-1:0];
        end
    end
endmodule

// File: shared/arj_pkg.sv
// package with register map and field layout for the result registers
package arj_pkg;
    localparam int RES_W = 10;
    localparam int BYTE_W = 8;
    localparam logic [11:0] OFF_HIGH = 12'h000;
    localparam logic [11:0] OFF_LOW = 12'h004;
    localparam logic [11:0] OFF_CTRL = 12'h008;
    localparam int FMT_BIT = 0;
    localparam int BUSY_BIT = 1;
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic FMT_LEFT = 1'b0;
    localparam logic FMT_RIGHT = 1'b1;
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_RESET = 12'h000;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
    localparam logic HREADY_ON = 1'h1;
    localparam logic HRESP_OKAY = 1'h0;
    localparam int LEFT_HIGH_SHIFT = 2;
    localparam int LEFT_LOW_POS = 6;
    localparam int RIGHT_HIGH_SHIFT = 8;
    localparam int RIGHT_HIGH_BITS = 2;
endpackage

// File: tb/arj_regs_properties.sv
// port checker for the result registers
`timescale 1ns/1ps
module arj_regs_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic conv_done,
    input wire logic [9:0] conversion_result,
    input wire logic result_format_select
);
    logic ap_read;
    logic ap_write;
    logic [11:0] ap_addr;
    logic dp_write;
    logic [11:0] dp_addr;
    logic loaded;
    logic [9:0] last_res;
    logic last_fmt;

    assign ap_read = hsel && hready && !hwrite
        && (htrans == arj_pkg::HTRANS_NONSEQ);
    assign ap_write = hsel && hready && hwrite
        && (htrans == arj_pkg::HTRANS_NONSEQ);
    assign ap_addr = haddr[arj_pkg::ADDR_W-1:0];

    // write data phase tracking
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dp_write <= 1'h0;
            dp_addr <= arj_pkg::ADDR_RESET;
        end else begin
            dp_write <= ap_write;
            if (ap_write) begin
                dp_addr <= ap_addr;
            end
        end
    end

    // bytes hold a loaded result until software rewrites one
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            loaded <= 1'h0;
        end else if (conv_done) begin
            loaded <= 1'h1;
        end else if (dp_write && (dp_addr == arj_pkg::OFF_HIGH
                     || dp_addr == arj_pkg::OFF_LOW)) begin
            loaded <= 1'h0;
        end
    end

    // last result and the format in force when it landed
    always_ff @(posedge mclk) begin
        if (conv_done) begin
            last_res <= conversion_result;
            last_fmt <= result_format_select;
        end
    end

    chk_bus_okay: assert property (@(posedge mclk)
        disable iff (!rst_n) hreadyout && !hresp)
        else $error("bus answer not ready and okay");

    chk_high_left: assert property (@(posedge mclk)
        disable iff (!rst_n)
        ap_read && ap_addr == arj_pkg::OFF_HIGH && loaded
        && last_fmt == arj_pkg::FMT_LEFT
        |=> hrdata[7:0] == $past(last_res[9:2]))
        else $error("high byte wrong in left format");

    chk_low_left: assert property (@(posedge mclk)
        disable iff (!rst_n)
        ap_read && ap_addr == arj_pkg::OFF_LOW && loaded
        && last_fmt == arj_pkg::FMT_LEFT
        |=> hrdata[7:6] == $past(last_res[1:0]))
        else $error("low byte wrong in left format");

    chk_high_right: assert property (@(posedge mclk)
        disable iff (!rst_n)
        ap_read && ap_addr == arj_pkg::OFF_HIGH && loaded
        && last_fmt == arj_pkg::FMT_RIGHT
        |=> hrdata[1:0] == $past(last_res[9:8]))
        else $error("high byte wrong in right format");

    chk_low_right: assert property (@(posedge mclk)
        disable iff (!rst_n)
        ap_read && ap_addr == arj_pkg::OFF_LOW && loaded
        && last_fmt == arj_pkg::FMT_RIGHT
        |=> hrdata[7:0] == $past(last_res[7:0]))
        else $error("low byte wrong in right format");

    chk_fmt_write: assert property (@(posedge mclk)
        disable iff (!rst_n)
        dp_write && dp_addr == arj_pkg::OFF_CTRL
        |=> result_format_select == $past(hwdata[arj_pkg::FMT_BIT]))
        else $error("format select not taken from write");

    chk_upper_zero: assert property (@(posedge mclk)
        disable iff (!rst_n)
        ap_read |=> hrdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
endmodule
bind arj_result_regs arj_regs_chk chk (
    .mclk(mclk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .conv_done(conv_done),
    .conversion_result(conversion_result),
    .result_format_select(result_format_select)
);

// File: tb/tb.sv
// bench for the result registers
`timescale 1ns/1ps
module tb;
    logic mclk = 0, rst_n = 0, hw = 0, cd = 0, rdy, fmt, rsp;
    logic [31:0] ha = 0, wd = 0, rd, q, eh, el;
    logic [1:0] tr = 0;
    logic [9:0] cr = 0;
    logic [9:0] r [4] = '{10'h3FF, 10'h2A5, 10'h15A, 10'h001};
    int fail_count = 0, cmp_count = 0, cyc = 0;
    arj_result_regs uut (.mclk(mclk), .rst_n(rst_n), .hsel(1'b1),
        .haddr(ha), .htrans(tr), .hwrite(hw), .hsize(3'h2), .hwdata(wd),
        .hready(rdy), .hrdata(rd), .hreadyout(rdy), .hresp(rsp),
        .conv_done(cd), .conversion_result(cr), .result_format_select(fmt));
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic xf(logic [3:0] a, logic w, logic [31:0] d);
        ha <= {28'h0, a};
        hw <= w;
        tr <= 2'h2;
        do @(posedge mclk); while (rdy !== 1'b1);
        tr <= 2'h0;
        wd <= d;
        do @(posedge mclk); while (rdy !== 1'b1);
        q = rd;
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) if (++cyc == 2000) begin
        fail_count++;
        print_verdict;
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk("hresp", {31'h0, rsp}, 32'h0);
        chk("format after reset", {31'h0, fmt}, 32'h0);
        xf(4'h0, 1'b1, 32'hA5);
        xf(4'h4, 1'b1, 32'h5A);
        xf(4'h0, 1'b0, 32'h0);
        chk("high rw", q, 32'hA5);
        xf(4'h4, 1'b0, 32'h0);
        chk("low rw", q, 32'h5A);
        xf(4'hC, 1'b0, 32'h0);
        chk("unmapped", q, 32'h0);
        foreach (r[i]) begin
            eh = i[0] ? r[i][9:8] : r[i][9:2];
            el = i[0] ? r[i][7:0] : {r[i][1:0], 6'h0};
            xf(4'h8, 1'b1, {30'h0, 1'b1, i[0]});
            cr <= r[i];
            cd <= 1'b1;
            @(posedge mclk);
            cd <= 1'b0;
            chk("format", {31'h0, fmt}, {31'h0, i[0]});
            xf(4'h8, 1'b0, 32'h0);
            chk("ctrl", q, {30'h0, 1'b1, i[0]});
            xf(4'h0, 1'b0, 32'h0);
            chk("high", q, eh);
            chk("high used", q & (i[0] ? 32'h3 : 32'hFF), eh);
            xf(4'h4, 1'b0, 32'h0);
            chk("low", q, el);
            chk("low used", q & (i[0] ? 32'hFF : 32'hC0), el);
        end
        xf(4'h8, 1'b1, 32'h2);
        xf(4'h8, 1'b0, 32'h0);
        chk("ctrl clear", q, 32'h0);
        print_verdict;
    end
endmodule
